// *** rtl/tmo_timer.sv ***
// 16-bit overflow timer with buffered wide access, Avalon-MM slave.
// Assumes one 40 MHz clock, synchronous active-low reset, sync inputs.
//
// How it works
// - The 16-bit count runs up from zero to all ones and wraps to zero.
// - A wrap from all ones to zero sets the overflow flag in flags bit 0.
// - The overflow raises the request only while enable bit 0 is set.
// - In wide mode the high byte address reaches a separate buffer.
// - In wide mode a low byte read copies the live high byte to the buffer.
// - In wide mode a low byte write also loads the high byte from buffer.
// - In wide mode the high address never reads or writes the live byte.
// - A high byte write leaves the prescaler count alone.
// - Only a low byte write clears the prescaler count.
// - Source select 0 counts each instruction cycle, 1 each rising ext edge.
// - The prescaler divides by 1, 2, 4 or 8 from the two-bit field.
// - With wide mode off each byte address reads and writes its live count byte directly.
// - The count advances only while the counter on bit is set.
//
// Implementation choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module tmo_timer (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic [tmo_pkg::ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic ext_clk_i,
   input wire logic lp_clk_active_i,
   output logic irq_o,
   output logic ovf_req_o,
   output logic lp_osc_enable_o
);
   import tmo_pkg::*;

   // ****************************************************************
   // Declarations
   // ****************************************************************
   logic [15:0] count_r;
   logic [7:0] hbuf_r;
   logic [7:0] ctrl_r;
   logic [7:0] flags_r;
   logic [7:0] enables_r;
   logic [7:0] prios_r;
   logic [1:0] ev_stat_r;
   logic [1:0] ev_en_r;
   logic [1:0] div_r;
   logic ext_q_r;
   logic ack_r;
   logic tick;
   logic step;
   logic wrap;
   logic acc;
   logic wr_acc;
   logic rd_acc;
   logic wr_low;
   logic wr_high;
   logic rd_low;
   logic wide;
   logic [7:0] wbyte;
   logic [7:0] rdata;
   logic [1:0] ev_set;

   // Byte lane 0 carries register data
   function automatic logic lane_ok(input logic [3:0] be);
      lane_ok = be[0];
   endfunction

   // ****************************************************************
   // Bus decode: one wait state, answer on second cycle
   // ****************************************************************
   assign acc = (avs_read_i | avs_write_i) & ack_r;
   assign wr_acc = acc & avs_write_i & lane_ok(avs_byteenable_i);
   assign rd_acc = acc & avs_read_i;
   assign wbyte = avs_writedata_i[7:0];
   assign wide = ctrl_r[CTL_WIDE];
   assign wr_low = wr_acc && (avs_address_i == ADDR_LOW);
   assign wr_high = wr_acc && (avs_address_i == ADDR_HIGH);
   assign rd_low = rd_acc && (avs_address_i == ADDR_LOW);

   // Waitrequest drops for one cycle after each request seen
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         ack_r <= 1'b0;
         avs_waitrequest_o <= 1'b1;
      end else if ((avs_read_i | avs_write_i) && !ack_r) begin
         ack_r <= 1'b1;
         avs_waitrequest_o <= 1'b0;
      end else begin
         ack_r <= 1'b0;
         avs_waitrequest_o <= 1'b1;
      end
   end

   // ****************************************************************
   // Count source and prescaler
   // ****************************************************************
   // Instruction cycle is every fourth system clock
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         div_r <= 2'h0;
         ext_q_r <= 1'b0;
      end else begin
         div_r <= 2'(div_r + 2'h1);
         ext_q_r <= ext_clk_i;
      end
   end

   // Internal or external rising edge, gated by counter on
   always_comb begin
      if (ctrl_r[CTL_SRC]) begin
         tick = ext_clk_i & ~ext_q_r;
      end else begin
         tick = (div_r == 2'h3);
      end
      tick = tick & ctrl_r[CTL_ON];
   end

   // Prescaler cleared by low byte writes only
   tmo_ps_div u_ps (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .tick_i(tick),
      .clr_i(wr_low),
      .sel_i(ctrl_r[CTL_PS_HI:CTL_PS_LO]),
      .step_o(step)
   );

   // Wide high writes reach only the buffer, so the wrap still counts
   assign wrap = step && (count_r == CNT_ONES) && !wr_low &&
      !(wr_high && !wide);

   // ****************************************************************
   // Counter and high byte buffer
   // ****************************************************************
   // Bus writes take priority over a count step
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         count_r <= CNT_ZERO;
      end else if (wr_low && wide) begin
         count_r <= {hbuf_r, wbyte};
      end else if (wr_low) begin
         count_r[7:0] <= wbyte;
      end else if (wr_high && !wide) begin
         count_r[15:8] <= wbyte;
      end else if (step) begin
         count_r <= 16'(count_r + 16'h0001);
      end
   end

   // In wide mode the buffer takes high byte writes and low byte read snapshots
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         hbuf_r <= BYTE_ZERO;
      end else if (wr_high && wide) begin
         hbuf_r <= wbyte;
      end else if (rd_low && wide) begin
         hbuf_r <= count_r[15:8];
      end
   end

   // ****************************************************************
   // Control, flag, enable and priority registers
   // ****************************************************************
   // Control; bit 6 follows the low-power clock status
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         ctrl_r <= CTL_RESET;
      end else if (wr_acc && avs_address_i == ADDR_CTRL) begin
         ctrl_r <= (wbyte & CTL_WMASK) |
            ({7'h00, lp_clk_active_i} << CTL_LPRUN);
      end else begin
         ctrl_r[CTL_LPRUN] <= lp_clk_active_i;
      end
   end

   // Overflow flag: set wins over a software clear
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         flags_r <= BYTE_ZERO;
      end else if (wr_acc && avs_address_i == ADDR_FLAGS) begin
         flags_r <= {7'h00, wbyte[OVF_BIT] | wrap};
      end else if (wrap) begin
         flags_r[OVF_BIT] <= 1'b1;
      end
   end

   // Enables and priorities, only bit 0 implemented
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         enables_r <= BYTE_ZERO;
         prios_r <= BYTE_ZERO;
      end else begin
         if (wr_acc && avs_address_i == ADDR_ENABLES) begin
            enables_r <= {7'h00, wbyte[OVF_BIT]};
         end
         if (wr_acc && avs_address_i == ADDR_PRIOS) begin
            prios_r <= {7'h00, wbyte[OVF_BIT]};
         end
      end
   end

   // ****************************************************************
   // Sticky event status, clear and enable
   // ****************************************************************
   assign ev_set = (wrap ? EV_OVF : 2'h0) | (wr_low ? EV_WR : 2'h0);

   // Clear by writing ones; a new event beats the clear
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         ev_stat_r <= 2'h0;
         ev_en_r <= 2'h0;
      end else begin
         if (wr_acc && avs_address_i == ADDR_CLR) begin
            ev_stat_r <= (ev_stat_r & ~wbyte[1:0]) | ev_set;
         end else begin
            ev_stat_r <= ev_stat_r | ev_set;
         end
         if (wr_acc && avs_address_i == ADDR_EVEN) begin
            ev_en_r <= wbyte[1:0];
         end
      end
   end

   // ****************************************************************
   // Outputs and read data
   // ****************************************************************
   // Registered outputs
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         irq_o <= 1'b0;
         ovf_req_o <= 1'b0;
         lp_osc_enable_o <= 1'b0;
      end else begin
         irq_o <= |(ev_stat_r & ev_en_r);
         ovf_req_o <= flags_r[OVF_BIT] & enables_r[OVF_BIT];
         lp_osc_enable_o <= ctrl_r[CTL_OSCEN];
      end
   end

   // Read multiplexer; unmapped addresses read zero
   always_comb begin
      if (avs_address_i == ADDR_FLAGS) begin
         rdata = flags_r;
      end else if (avs_address_i == ADDR_ENABLES) begin
         rdata = enables_r;
      end else if (avs_address_i == ADDR_PRIOS) begin
         rdata = prios_r;
      end else if (avs_address_i == ADDR_LOW) begin
         rdata = count_r[7:0];
      end else if (avs_address_i == ADDR_HIGH) begin
         rdata = wide ? hbuf_r : count_r[15:8];
      end else if (avs_address_i == ADDR_CTRL) begin
         rdata = ctrl_r;
      end else if (avs_address_i == ADDR_STAT) begin
         rdata = {6'h00, ev_stat_r};
      end else if (avs_address_i == ADDR_EVEN) begin
         rdata = {6'h00, ev_en_r};
      end else begin
         rdata = BYTE_ZERO;
      end
   end

   // Read data captured on the answer edge setup
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         avs_readdata_o <= RD_ZERO;
      end else if (avs_read_i && !ack_r) begin
         avs_readdata_o <= {24'h000000, rdata};
      end
   end
endmodule // tmo_timer
`default_nettype wire

// *** rtl/tmo_pkg.sv ***
// Package for the 16-bit overflow timer: register map, fields, resets.
// Assumes a 40 MHz system clock and a 32-bit Avalon-MM register slave.
package tmo_pkg;
   // ****************************************************************
   // Register word addresses (byte address = 4 * index)
   // ****************************************************************
   localparam logic [3:0] ADDR_FLAGS = 4'h0;   // peripheral_irq_flags
   localparam logic [3:0] ADDR_ENABLES = 4'h1; // peripheral_irq_enables
   localparam logic [3:0] ADDR_PRIOS = 4'h2;   // peripheral_irq_priorities
   localparam logic [3:0] ADDR_LOW = 4'h3;     // count_low_byte
   localparam logic [3:0] ADDR_HIGH = 4'h4;    // count_high_byte
   localparam logic [3:0] ADDR_CTRL = 4'h5;    // counter_control
   localparam logic [3:0] ADDR_STAT = 4'h6;    // sticky event status
   localparam logic [3:0] ADDR_CLR = 4'h7;     // event clear, write only
   localparam logic [3:0] ADDR_EVEN = 4'h8;    // event enable
   localparam int ADDR_W = 4;

   // ****************************************************************
   // Control register fields
   // ****************************************************************
   localparam int CTL_ON = 0;
   localparam int CTL_SRC = 1;
   localparam int CTL_NOSYNC = 2;
   localparam int CTL_OSCEN = 3;
   localparam int CTL_PS_LO = 4;
   localparam int CTL_PS_HI = 5;
   localparam int CTL_LPRUN = 6;
   localparam int CTL_WIDE = 7;
   localparam logic [7:0] CTL_WMASK = 8'hbf; // bit 6 is read only
   localparam logic [7:0] CTL_RESET = 8'h00;

   // ****************************************************************
   // Flag / event fields and reset values
   // ****************************************************************
   localparam int OVF_BIT = 0;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [15:0] CNT_ZERO = 16'h0000;
   localparam logic [15:0] CNT_ONES = 16'hffff;
   localparam logic [1:0] EV_OVF = 2'h1;  // overflow event
   localparam logic [1:0] EV_WR = 2'h2;   // prescaler cleared by write
   localparam logic [2:0] PS_ZERO = 3'h0;
   localparam logic [31:0] RD_ZERO = 32'h0000_0000;
endpackage

// *** rtl/tmo_ps_div.sv ***
// Input prescaler for the overflow timer: turns count ticks into enables.
// Assumes tick_i is a one-cycle pulse in the system clock domain.
`timescale 1ns/1ps
`default_nettype none
module tmo_ps_div (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic tick_i,
   input wire logic clr_i,
   input wire logic [1:0] sel_i,
   output logic step_o
);
   import tmo_pkg::*;
   logic [2:0] cnt_r;
   logic [2:0] lim;

   // Terminal count for 1:1, 1:2, 1:4, 1:8
   always_comb begin
      lim = 3'((3'h1 << sel_i) - 3'h1);
   end

   // Ticks divided down; cleared on low byte writes
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         cnt_r <= PS_ZERO;
         step_o <= 1'b0;
      end else if (clr_i) begin
         cnt_r <= PS_ZERO;
         step_o <= 1'b0;
      end else if (tick_i) begin
         step_o <= (cnt_r >= lim);
         cnt_r <= (cnt_r >= lim) ? PS_ZERO : 3'(cnt_r + 3'h1);
      end else begin
         step_o <= 1'b0;
      end
   end
endmodule // tmo_ps_div
`default_nettype wire

// *** verif/tmo_timer_asserts.sv ***
// Checker for the overflow timer: bus handshake and level outputs.
// Assumes it is bound to tmo_timer and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module tmo_timer_asserts (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic [tmo_pkg::ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   input wire logic irq_o,
   input wire logic ovf_req_o,
   input wire logic lp_osc_enable_o
);
   import tmo_pkg::*;
   // ********
   // Helpers
   // ********
   logic req;
   logic wr0;
   // Request taken this edge, and a low-lane write
   assign req = (avs_read_i || avs_write_i) && avs_waitrequest_o;
   assign wr0 = req && avs_write_i && avs_byteenable_i[0];
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   a_one_wait: assert property (req |=> !avs_waitrequest_o)
      else $error("request not answered after one wait");
   a_ack_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("waitrequest low for two cycles");
   a_ack_cause: assert property (!avs_waitrequest_o |-> $past(req))
      else $error("answer without a request");
   a_rd_upper: assert property (avs_readdata_o[31:8] == 24'h000000)
      else $error("read data upper bits not zero");
   a_unmapped_rd: assert property (req && avs_read_i &&
      avs_address_i > ADDR_EVEN |=> avs_readdata_o == RD_ZERO)
      else $error("unmapped read not zero");
   a_ovf_mask: assert property (wr0 && avs_address_i == ADDR_ENABLES &&
      !avs_writedata_i[OVF_BIT] |-> ##3 !ovf_req_o)
      else $error("overflow request while disabled");
   a_irq_mask: assert property (wr0 && avs_address_i == ADDR_EVEN &&
      avs_writedata_i[1:0] == 2'h0 |-> ##3 !irq_o)
      else $error("interrupt while all events masked");
   a_osc_follow: assert property (wr0 && avs_address_i == ADDR_CTRL |->
      ##3 lp_osc_enable_o == $past(avs_writedata_i[CTL_OSCEN], 3))
      else $error("oscillator enable not following control");
endmodule // tmo_timer_asserts
`default_nettype wire

// *** verif/tmo_cpu_model.sv ***
// Processor core model: byte-wide Avalon-MM register master.
// Assumes the slave answers by waitrequest; the bench cuts hangs.
`timescale 1ns/1ps
`default_nettype none
module tmo_cpu_model (
   input wire logic sys_clk_i,
   input wire logic waitrequest_i,
   output logic [tmo_pkg::ADDR_W-1:0] address_o,
   output logic read_o,
   output logic write_o,
   output logic [31:0] writedata_o,
   output logic [3:0] byteenable_o
);
   import tmo_pkg::*;
   // Idle bus from time zero
   initial begin
      address_o = 4'h0;
      read_o = 1'b0;
      write_o = 1'b0;
      writedata_o = 32'h00000000;
      byteenable_o = 4'hf;
   end
   // One transfer, held until waitrequest is sampled low
   task automatic xfer(input logic w, input logic [3:0] a,
      input logic [7:0] d);
      @(posedge sys_clk_i);
      address_o <= a;
      read_o <= !w;
      write_o <= w;
      writedata_o <= {24'h000000, d};
      do @(posedge sys_clk_i); while (waitrequest_i !== 1'b0);
      read_o <= 1'b0;
      write_o <= 1'b0;
   endtask
   // Timekeeping setup: top bit of high byte only, ext counting, oscillator on
   task automatic rtc_setup();
      xfer(1'b1, ADDR_HIGH, 8'h80);
      xfer(1'b1, ADDR_CTRL, 8'h0f);
   endtask
endmodule // tmo_cpu_model
`default_nettype wire

// *** verif/tmo_timer_tb.sv ***
// Self-checking bench for tmo_timer: access modes, counting, events.
// Assumes tmo_cpu_model as bus master and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module tmo_timer_tb;
   import tmo_pkg::*;
   logic sys_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic ext_clk_i = 1'b0;
   logic lp_clk_active_i = 1'b0;
   logic [3:0] adr;
   logic rd;
   logic wr;
   logic [31:0] wd;
   logic [31:0] rdat;
   logic [3:0] be;
   logic wt;
   logic irq;
   logic ovf;
   logic lpo;
   logic [31:0] seed = 32'h00008783; // 34691
   logic [31:0] exp_q[$];
   int err_total = 0;
   int comparisons = 0;
   int cyc = 0;
   tmo_timer uut (.sys_clk_i, .rst_n_i, .avs_address_i(adr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
      .avs_byteenable_i(be), .avs_readdata_o(rdat),
      .avs_waitrequest_o(wt), .ext_clk_i, .lp_clk_active_i,
      .irq_o(irq), .ovf_req_o(ovf), .lp_osc_enable_o(lpo));
   tmo_cpu_model cpu (.sys_clk_i, .waitrequest_i(wt), .address_o(adr),
      .read_o(rd), .write_o(wr), .writedata_o(wd), .byteenable_o(be));
   // ********
   // Helpers
   // ********
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] want);
      comparisons++;
      if (seen !== want) begin
         err_total++;
         $display("Error %0t: saw %h expected %h", $time, seen, want);
      end
   endtask
   task automatic w(input logic [3:0] a, input logic [7:0] d);
      cpu.xfer(1'b1, a, d);
   endtask
   task automatic r(input logic [3:0] a, input logic [7:0] e);
      exp_q.push_back({24'h000000, e});
      cpu.xfer(1'b0, a, 8'h00);
   endtask
   task automatic pulse(input int n);
      repeat (n) begin
         ext_clk_i <= 1'b1;
         repeat (2) @(posedge sys_clk_i);
         ext_clk_i <= 1'b0;
         repeat (2) @(posedge sys_clk_i);
      end
      repeat (4) @(posedge sys_clk_i);
   endtask
   // Levels irq, overflow request, oscillator enable once settled
   task automatic lvl(input logic [2:0] want);
      repeat (4) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      chk({29'h0, irq, ovf, lpo}, {29'h0, want});
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Clock
   initial begin
      forever #12.5 sys_clk_i = ~sys_clk_i;
   end
   // Read result monitor and hang limit
   always @(posedge sys_clk_i) begin
      cyc++;
      if (rd && wt === 1'b0)
         chk(rdat, exp_q.pop_front());
      if (cyc == 20000) begin
         err_total++;
         complete_run();
      end
   end
   // ********
   // Scenarios
   // ********
   initial begin
      repeat (6) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      r(ADDR_CTRL, 8'h00);
      w(4'hf, 8'hff);
      r(4'hf, 8'h00);
      lvl(3'b000);
      $display("reset test done");
      seed = xs(seed);
      lp_clk_active_i <= seed[8];
      w(ADDR_LOW, seed[7:0]);
      cpu.rtc_setup();
      r(ADDR_LOW, seed[7:0]);
      r(ADDR_HIGH, 8'h80);
      r(ADDR_CTRL, {1'b0, seed[8], 6'h0f});
      w(ADDR_CTRL, 8'h02);
      pulse(3);
      r(ADDR_LOW, seed[7:0]);
      $display("narrow test done");
      w(ADDR_LOW, 8'h5a);
      w(ADDR_HIGH, 8'h3c);
      w(ADDR_CTRL, 8'h80);
      w(ADDR_HIGH, 8'h77);
      r(ADDR_HIGH, 8'h77);
      w(ADDR_CTRL, 8'h00);
      r(ADDR_HIGH, 8'h3c);
      w(ADDR_CTRL, 8'h80);
      w(ADDR_HIGH, 8'hc3);
      w(ADDR_LOW, 8'ha5);
      w(ADDR_HIGH, 8'h11);
      r(ADDR_LOW, 8'ha5);
      r(ADDR_HIGH, 8'hc3);
      $display("wide test done");
      for (int k = 0; k < 4; k++) begin
         w(ADDR_CTRL, 8'h00);
         w(ADDR_LOW, 8'h00);
         w(ADDR_CTRL, 8'h03 | 8'(k << 4));
         pulse((2 << k) - 1);
         r(ADDR_LOW, 8'h01);
      end
      w(ADDR_LOW, 8'h00);
      pulse(4);
      w(ADDR_HIGH, 8'h00);
      pulse(4);
      r(ADDR_LOW, 8'h01);
      pulse(4);
      w(ADDR_LOW, 8'h00);
      pulse(4);
      r(ADDR_LOW, 8'h00);
      $display("prescale test done");
      w(ADDR_CTRL, 8'h00);
      w(ADDR_LOW, 8'h00);
      w(ADDR_CTRL, 8'h01);
      // Internal source on for 44 edges: 11 instruction ticks
      repeat (41) @(posedge sys_clk_i);
      w(ADDR_CTRL, 8'h00);
      r(ADDR_LOW, 8'h0b);
      $display("internal source test done");
      w(ADDR_ENABLES, 8'h00);
      w(ADDR_EVEN, 8'h00);
      w(ADDR_CLR, 8'h03);
      w(ADDR_FLAGS, 8'h00);
      w(ADDR_LOW, 8'hff);
      w(ADDR_HIGH, 8'hff);
      w(ADDR_CTRL, 8'h0f);
      pulse(1);
      r(ADDR_HIGH, 8'h00);
      r(ADDR_LOW, 8'h00);
      r(ADDR_FLAGS, 8'h01);
      r(ADDR_STAT, 8'h03);
      lvl(3'b001);
      w(ADDR_ENABLES, 8'h01);
      w(ADDR_EVEN, 8'h01);
      lvl(3'b111);
      w(ADDR_CLR, 8'h01);
      lvl(3'b011);
      pulse(2);
      r(ADDR_FLAGS, 8'h01);
      w(ADDR_FLAGS, 8'h00);
      lvl(3'b001);
      $display("overflow test done");
      complete_run();
   end
endmodule // tmo_timer_tb
bind tmo_timer tmo_timer_asserts chk_u (.sys_clk_i, .rst_n_i,
   .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
   .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .irq_o,
   .ovf_req_o, .lp_osc_enable_o);
`default_nettype wire
